// File: adc_mode_sequencer.sv
`timescale 1ns/1ps
// How it works
// - Chop enable bit set cancels offset using opposite-polarity conversion pairs.
// - Normal then inverted polarity; output mean of each overlapping adjacent pair.
// - Filter restarts at each swap; three internal conversions per chopped result.
// - Settling delay after each swap chosen by four-bit field, 2 to 65536.
// - Steady chop period equals delay plus three times oversampling ratio.
// - Result-ready falls each time a new chopped result is available.
// - With chop enabled, sync falling edge or oversampling-ratio change restarts all channels together.
// - First result after restart needs two full intervals plus 44 periods.
// - Phase calibration is ignored and treated as off during chop.
// - Two-bit power field selects high-resolution, low or minimum power.
// - Standby command disables channels, powers down, keeps all registers.
// - Wakeup command leaves standby; sampling starts eight periods after clock.
// - Short sync low pulse in standby only enters current-detect mode.
// - Detect mode takes configured samples near 2.7 kSPS, compares absolute value.
// - Enough hits signal result-ready falling edge then return to standby.
// - Detect mode runs from internal oscillator; conversions never reach the host.
// - Detect level is 24 bits in upper and lower registers plus enable.
// - Three-bit sample-count field sets samples per pass, 128 to 3584.
// - Three-bit hit-count field sets exceedances needed for a detection.
// - All-channels bit requires every enabled channel, else any enabled one.
// - Sync held low past threshold resets device until pin returns high.
module adms_sequencer #(
	parameter int CHANNELS = 3,
	parameter int RESET_PULSE_THRESHOLD = 4096,
	parameter logic [31:0] MOD_DIV = 32'd2,
	parameter logic [16:0] SETTLE_LUT [16] = '{17'd2, 17'd4, 17'd8, 17'd16, 17'd32,
		17'd64, 17'd128, 17'd256, 17'd512, 17'd1024, 17'd2048, 17'd4096, 17'd8192,
		17'd16384, 17'd32768, 17'd65536},
	parameter logic [11:0] SAMPLE_LUT [8] = '{12'd128, 12'd256, 12'd512, 12'd768,
		12'd1280, 12'd1792, 12'd2560, 12'd3584},
	parameter logic [11:0] HIT_LUT [8] = '{12'd1, 12'd2, 12'd4, 12'd8, 12'd16, 12'd32,
		12'd64, 12'd128}
) (
	input wire logic core_clk, // System clock, 50 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic syncResetN, // Sync/reset pin, asynchronous.
	input wire logic modClockRun, // Master clock toggling indication, asynchronous.
	input wire logic convDone, // Filter conversion complete strobe.
	input wire logic signed [23:0] convData [CHANNELS], // Raw filter outputs.
	output logic filterRestart, // Filter reset request pulse.
	output logic polarityInvert, // Input polarity, high when swapped.
	output logic modulatorRun, // Modulator sampling enable.
	output logic internalOscOn, // Internal oscillator enable.
	output logic [CHANNELS-1:0] channelActive, // Channel power enables.
	output logic [1:0] powerLevel, // Power level to analog front end.
	output logic phaseCalEnable, // Phase calibration permitted.
	output logic dcTestSelect, // DC test signal routed to inputs.
	output logic resultReadyN, // Result-ready pin, active low.
	output logic deviceResetActive // Device held in reset by the pin.
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETTLE, ST_CONVERT, ST_STANDBY, ST_WAKE, ST_DETECT
	} adms_state_type;

	adms_state_type state_reg, state_next;
	logic [31:0] chopCfg_reg, clock_reg, detectCfg_reg;
	logic [23:0] levelUpper_reg, levelLower_reg;
	logic [1:0] syncMeta_reg, clkMeta_reg;
	logic syncOld_reg;
	logic [31:0] lowCount_reg;
	logic [31:0] modDiv_reg;
	logic [17:0] settle_reg;
	logic [1:0] pass_reg;
	logic firstDone_reg;
	logic signed [24:0] prevResult_reg [CHANNELS];
	logic [23:0] result_reg [CHANNELS];
	logic [31:0] detDiv_reg;
	logic [11:0] sampleCnt_reg;
	logic [11:0] hitCnt_reg [CHANNELS];
	logic readyN_reg;
	logic [6:0] extra_reg;
	logic [3:0] wakeCnt_reg;

	// Pin inputs pass two flops; only the second stage is read.
	wire syncPin = syncMeta_reg[1];
	wire clkRunning = clkMeta_reg[1];
	wire syncFall = syncOld_reg & ~syncPin;
	wire syncRise = ~syncOld_reg & syncPin;
	wire longLow = ~syncPin && lowCount_reg >= RESET_PULSE_THRESHOLD;
	wire modTick = modDiv_reg == MOD_DIV - 32'd1;

	// Register decode.
	wire apbAccess = psel & penable;
	wire apbWrite = apbAccess & pwrite;
	wire hitChop = paddr == adms_pkg::OFS_CHOP_CFG;
	wire hitClock = paddr == adms_pkg::OFS_CLOCK;
	wire hitDetCfg = paddr == adms_pkg::OFS_DETECT_CFG;
	wire hitUpper = paddr == adms_pkg::OFS_DETECT_UPPER;
	wire hitLower = paddr == adms_pkg::OFS_DETECT_LOWER;
	wire hitStatus = paddr == adms_pkg::OFS_STATUS;
	wire hitCmd = paddr == adms_pkg::OFS_SERIAL_CMD;
	wire hitResult = paddr == adms_pkg::OFS_RESULT;
	wire mapped = hitChop | hitClock | hitDetCfg | hitUpper | hitLower | hitStatus | hitCmd
		| hitResult;
	wire cmdStandby = apbWrite & hitCmd & pwdata[15:0] == adms_pkg::CMD_STANDBY;
	wire cmdWakeup = apbWrite & hitCmd & pwdata[15:0] == adms_pkg::CMD_WAKEUP;
	wire osrWrite = apbWrite & hitClock &
		pwdata[adms_pkg::OSR_LSB +: 4] != clock_reg[adms_pkg::OSR_LSB +: 4];

	// Field views.
	wire chopOn = chopCfg_reg[adms_pkg::CHOP_EN_POS];
	wire [3:0] delayCode = chopCfg_reg[adms_pkg::CHOP_DLY_LSB +: 4];
	wire [CHANNELS-1:0] chEn = clock_reg[adms_pkg::CH_EN_LSB +: CHANNELS];
	wire [3:0] osrCode = clock_reg[adms_pkg::OSR_LSB +: 4];
	// Oversampling ratio is 128 shifted left by the low three bits of the code.
	wire [17:0] oversampling_ratio = 18'd128 << osrCode[2:0];
	wire detEn = detectCfg_reg[adms_pkg::DET_EN_POS];
	wire detAll = detectCfg_reg[adms_pkg::DET_ALL_POS];
	wire [16:0] settleLen = SETTLE_LUT[delayCode];
	wire [11:0] sampleLen = SAMPLE_LUT[detectCfg_reg[adms_pkg::DET_LEN_LSB +: 3]];
	wire [11:0] hitLen = HIT_LUT[detectCfg_reg[adms_pkg::DET_NUM_LSB +: 3]];
	wire [23:0] level = {levelUpper_reg[15:0], levelLower_reg[7:0]};
	wire detTick = detDiv_reg == 32'(adms_pkg::DETECT_DIV - 1);

	// Per-channel threshold compare on absolute values.
	logic [CHANNELS-1:0] overLevel, hitMet;
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			overLevel[i] = (convData[i][23] ? 24'(-convData[i]) : 24'(convData[i])) > level;
			hitMet[i] = hitCnt_reg[i] >= hitLen;
		end
	end
	wire detectHit = detAll ? ((hitMet & chEn) == chEn && chEn != '0) : |(hitMet & chEn);

	// Sequencer next state.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = chopOn ? ST_SETTLE : ST_IDLE;
			ST_SETTLE: if (settle_reg == '0) begin
				state_next = ST_CONVERT;
			end
			ST_CONVERT: if (!chopOn) begin
				state_next = ST_IDLE;
			end
			ST_STANDBY: if (syncRise && detEn) begin
				state_next = ST_DETECT;
			end else if (cmdWakeup) begin
				state_next = ST_WAKE;
			end
			ST_WAKE: if (clkRunning && wakeCnt_reg == 4'(adms_pkg::WAKE_SETTLE_MOD)) begin
				state_next = ST_IDLE;
			end
			ST_DETECT: if (detectHit || sampleCnt_reg >= sampleLen) begin
				state_next = ST_STANDBY;
			end
			default: state_next = ST_IDLE;
		endcase
		if (cmdStandby && state_reg != ST_DETECT) begin
			state_next = ST_STANDBY;
		end
	end

	// Pin synchronisers and low-time counter.
	always_ff @(posedge core_clk) begin
		syncMeta_reg <= {syncMeta_reg[0], syncResetN};
		clkMeta_reg <= {clkMeta_reg[0], modClockRun};
		syncOld_reg <= syncPin;
		lowCount_reg <= syncPin ? 32'd0 : lowCount_reg + (longLow ? 32'd0 : 32'd1);
	end

	// Registers keep their values across standby; only reset clears them.
	always_ff @(posedge core_clk) begin
		if (srst || longLow) begin
			chopCfg_reg <= adms_pkg::CHOP_CFG_RST;
			clock_reg <= adms_pkg::CLOCK_RST;
			detectCfg_reg <= adms_pkg::DETECT_CFG_RST;
			levelUpper_reg <= adms_pkg::DETECT_LEVEL_RST;
			levelLower_reg <= adms_pkg::DETECT_LEVEL_RST;
		end else if (apbWrite) begin
			if (hitChop) chopCfg_reg <= pwdata;
			if (hitClock) clock_reg <= pwdata;
			if (hitDetCfg) detectCfg_reg <= pwdata;
			if (hitUpper) levelUpper_reg <= {8'h00, pwdata[15:0]};
			if (hitLower) levelLower_reg <= {16'h0000, pwdata[7:0]};
		end
	end

	// Chop sequencing: settle, three passes, average the pair.
	always_ff @(posedge core_clk) begin
		if (srst || longLow) begin
			state_reg <= ST_IDLE;
			modDiv_reg <= '0;
			settle_reg <= '0;
			pass_reg <= '0;
			firstDone_reg <= 1'b0;
			polarityInvert <= 1'b0;
			filterRestart <= 1'b0;
			readyN_reg <= 1'b1;
			extra_reg <= '0;
			wakeCnt_reg <= '0;
			detDiv_reg <= '0;
			sampleCnt_reg <= '0;
			for (int i = 0; i < CHANNELS; i++) begin
				prevResult_reg[i] <= '0;
				result_reg[i] <= '0;
				hitCnt_reg[i] <= '0;
			end
		end else begin
			state_reg <= state_next;
			modDiv_reg <= modTick ? 32'd0 : modDiv_reg + 32'd1;
			filterRestart <= 1'b0;
			readyN_reg <= 1'b1;
			if (state_reg == ST_WAKE && clkRunning && modTick) begin
				wakeCnt_reg <= wakeCnt_reg + 4'd1;
			end else if (state_reg != ST_WAKE) begin
				wakeCnt_reg <= '0;
			end
			// synchronous restart
			// A standby command in the same cycle wins over a restart.
			if (chopOn && (syncFall || osrWrite) && state_reg != ST_STANDBY && !cmdStandby) begin
				state_reg <= ST_SETTLE;
				settle_reg <= 18'(settleLen);
				pass_reg <= '0;
				firstDone_reg <= 1'b0;
				polarityInvert <= 1'b0;
				filterRestart <= 1'b1;
				extra_reg <= 7'(adms_pkg::FIRST_EXTRA_MOD);
			end else if (state_reg == ST_IDLE && chopOn) begin
				settle_reg <= 18'(settleLen);
				filterRestart <= 1'b1;
				extra_reg <= 7'(adms_pkg::FIRST_EXTRA_MOD);
			end else if (state_reg == ST_SETTLE && modTick && settle_reg != '0) begin
				settle_reg <= settle_reg - 18'd1;
			end else if (state_reg == ST_CONVERT && convDone) begin
				if (pass_reg == 2'(adms_pkg::CHOP_PASSES - 1)) begin
					pass_reg <= '0;
					filterRestart <= 1'b1;
					polarityInvert <= ~polarityInvert;
					settle_reg <= 18'(settleLen);
					if (!cmdStandby) begin
						state_reg <= ST_SETTLE;
					end
					for (int i = 0; i < CHANNELS; i++) begin
						prevResult_reg[i] <= polarityInvert ? -25'(convData[i]) : 25'(convData[i]);
						result_reg[i] <= 24'((prevResult_reg[i] + (polarityInvert ?
							-25'(convData[i]) : 25'(convData[i]))) >>> 1);
					end
					firstDone_reg <= 1'b1;
					if (firstDone_reg && extra_reg == '0) begin
						readyN_reg <= 1'b0;
					end
				end else begin
					pass_reg <= pass_reg + 2'd1;
				end
			end
			if (firstDone_reg && extra_reg != '0 && modTick) begin
				extra_reg <= extra_reg - 7'd1;
			end
			if (state_reg == ST_DETECT) begin
				detDiv_reg <= detTick ? 32'd0 : detDiv_reg + 32'd1;
				if (detTick) begin
					sampleCnt_reg <= sampleCnt_reg + 12'd1;
					for (int i = 0; i < CHANNELS; i++) begin
						if (overLevel[i] && chEn[i] && !hitMet[i]) begin
							hitCnt_reg[i] <= hitCnt_reg[i] + 12'd1;
						end
					end
				end
				if (detectHit) begin
					readyN_reg <= 1'b0;
				end
			end else begin
				detDiv_reg <= '0;
				sampleCnt_reg <= '0;
				for (int i = 0; i < CHANNELS; i++) begin
					hitCnt_reg[i] <= '0;
				end
			end
		end
	end

	// Front-end controls.
	wire inStandby = state_reg == ST_STANDBY;
	assign channelActive = (inStandby || state_reg == ST_WAKE) ? '0 : chEn;
	assign modulatorRun = state_reg inside {ST_IDLE, ST_SETTLE, ST_CONVERT};
	assign internalOscOn = state_reg == ST_DETECT;
	assign powerLevel = clock_reg[adms_pkg::PWR_LSB +: 2];
	assign phaseCalEnable = ~chopOn;
	assign dcTestSelect = chopCfg_reg[adms_pkg::DC_TEST_POS] & ~chopOn;
	assign resultReadyN = readyN_reg;
	assign deviceResetActive = longLow;

	// APB answers in the access cycle; detect conversions are never readable.
	assign pready = 1'b1;
	assign pslverr = apbAccess & ~mapped;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= hitChop ? chopCfg_reg : hitClock ? clock_reg : hitDetCfg ? detectCfg_reg
				: hitUpper ? {8'h00, levelUpper_reg} : hitLower ? {8'h00, levelLower_reg}
				: hitStatus ? {28'h0, polarityInvert, 3'(state_reg)}
				: hitResult ? {8'h00, result_reg[0]} : 32'h0000_0000;
		end
	end
endmodule // adms_sequencer

// File: adms_filter_model.sv
`timescale 1ns/1ps
// Filter stand-in: one conversion every CONV_CYC cycles while running, with an offset.
module adms_filter_model #(
	parameter int CONV_CYC = 16,
	parameter logic signed [23:0] OFFSET = 24'sh000064
) (
	input wire logic core_clk, // Clock.
	input wire logic running, // Modulator or oscillator on.
	input wire logic filterRestart, // Restart request.
	input wire logic polarityInvert, // Inputs swapped.
	input wire logic signed [23:0] amp, // Input signal.
	output logic convDone, // Conversion strobe.
	output logic signed [23:0] convData [3] // Conversion words.
);
	int cnt = 0;
	int tick = 0;
	// Idle words change every cycle so a stale word never passes for a result.
	always_ff @(posedge core_clk) begin
		tick <= tick + 1;
		convDone <= 1'b0;
		if (!running || filterRestart) begin
			cnt <= 0;
		end else if (cnt == CONV_CYC - 1) begin
			cnt <= 0;
			convDone <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
		for (int i = 0; i < 3; i++) begin
			convData[i] <= running ? (polarityInvert ? -amp : amp) + OFFSET : tick[23:0];
		end
	end
endmodule // adms_filter_model

// File: adms_pkg.sv
package adms_pkg;

	// Serial command codes.
	localparam logic [15:0] CMD_STANDBY = 16'h0022;
	localparam logic [15:0] CMD_WAKEUP = 16'h0033;

	// Register byte offsets.
	localparam logic [7:0] OFS_CHOP_CFG = 8'h00;
	localparam logic [7:0] OFS_CLOCK = 8'h04;
	localparam logic [7:0] OFS_DETECT_CFG = 8'h08;
	localparam logic [7:0] OFS_DETECT_UPPER = 8'h0c;
	localparam logic [7:0] OFS_DETECT_LOWER = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_SERIAL_CMD = 8'h18;
	localparam logic [7:0] OFS_RESULT = 8'h1c;

	// Chop configuration fields.
	localparam int CHOP_EN_POS = 0;
	localparam int CHOP_DLY_LSB = 4;
	localparam int DC_TEST_POS = 8;
	// Clock register fields.
	localparam int CH_EN_LSB = 0;
	localparam int PWR_LSB = 8;
	localparam int OSR_LSB = 12;
	// Detect configuration fields.
	localparam int DET_EN_POS = 0;
	localparam int DET_ALL_POS = 1;
	localparam int DET_LEN_LSB = 4;
	localparam int DET_NUM_LSB = 8;

	// Reset values.
	localparam logic [31:0] CHOP_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CLOCK_RST = 32'h0000_2207;
	localparam logic [31:0] DETECT_CFG_RST = 32'h0000_0000;
	localparam logic [23:0] DETECT_LEVEL_RST = 24'h000000;

	// Timing counts in modulator periods; CHOP_PASSES counts conversions per chop phase.
	localparam int WAKE_SETTLE_MOD = 8;
	localparam int FIRST_EXTRA_MOD = 44;
	localparam int CHOP_PASSES = 3;
	// Internal oscillator divider: 50 MHz / 2.7 kSPS, rounded down.
	localparam int DETECT_RATE_HZ = 2700;
	localparam int CLK_HZ = 50_000_000;
	localparam int DETECT_DIV = CLK_HZ / DETECT_RATE_HZ;

	typedef enum logic [1:0] {
		HIGH_RESOLUTION_LEVEL,
		REDUCED_POWER_LEVEL,
		MINIMUM_POWER_LEVEL,
		RESERVED_LEVEL
	} adms_power_type;

	// APB request bundle.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} adms_apb_req_type;

endpackage

// File: adms_seq_monitor.sv
`timescale 1ns/1ps
// Watches the sequencer pins against a shadow of the settings written over APB.
module adms_seq_monitor #(
	parameter int RESET_PULSE_THRESHOLD = 16
) (
	input wire logic core_clk, // Clock.
	input wire logic srst, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pwrite, // Direction.
	input wire logic [7:0] paddr, // Address.
	input wire logic [31:0] pwdata, // Write data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic syncResetN, // Sync pin.
	input wire logic filterRestart, // Restart pulse.
	input wire logic internalOscOn, // Oscillator on.
	input wire logic [2:0] channelActive, // Channel power.
	input wire logic [1:0] powerLevel, // Power level.
	input wire logic phaseCalEnable, // Phase calibration.
	input wire logic resultReadyN, // Ready pin.
	input wire logic deviceResetActive // Pin reset.
);
	logic chopReg;
	logic stbyReg;
	logic [1:0] pwrReg;
	int lowCnt;
	wire wrHit = psel && penable && pwrite;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// Shadow settings; a pin reset restores the defaults just as the device does.
	always_ff @(posedge core_clk) begin
		if (srst || deviceResetActive) begin
			chopReg <= 1'b0;
			stbyReg <= 1'b0;
			pwrReg <= 2'h2;
		end else if (wrHit && paddr == adms_pkg::OFS_CHOP_CFG) begin
			chopReg <= pwdata[0];
		end else if (wrHit && paddr == adms_pkg::OFS_CLOCK) begin
			pwrReg <= pwdata[9:8];
		end else if (wrHit && paddr == adms_pkg::OFS_SERIAL_CMD) begin
			stbyReg <= pwdata[15:0] == adms_pkg::CMD_STANDBY;
		end
	end
	// Saturating length of the low phase of the sync pin.
	always_ff @(posedge core_clk) begin
		if (srst || syncResetN) lowCnt <= 0;
		else if (lowCnt < 1000) lowCnt <= lowCnt + 1;
	end
	sequence s_pin_back;
		$rose(syncResetN);
	endsequence
	a_ready_high: assert property (psel |-> pready) else $error("pready low");
	a_err_unmapped: assert property (
		psel && penable && paddr > 8'h1c |-> pslverr) else $error("no pslverr");
	a_phase_off: assert property (
		chopReg |-> !phaseCalEnable) else $error("phase cal on in chop");
	a_ready_pulse: assert property (
		$fell(resultReadyN) |=> resultReadyN) else $error("ready pulse long");
	a_restart_pulse: assert property (
		filterRestart |=> !filterRestart) else $error("restart pulse long");
	a_power_follow: assert property (disable iff (srst || deviceResetActive)
		!stbyReg |-> powerLevel == pwrReg) else $error("power level wrong");
	a_standby_off: assert property (
		stbyReg && !internalOscOn |-> channelActive == 3'h0) else $error("channel on");
	a_pin_reset: assert property (
		lowCnt > RESET_PULSE_THRESHOLD + 4 |-> deviceResetActive) else $error("no reset");
	a_pin_release: assert property (
		s_pin_back |-> ##[1:4] !deviceResetActive) else $error("reset stuck");
endmodule // adms_seq_monitor
bind adms_sequencer adms_seq_monitor #(.RESET_PULSE_THRESHOLD(RESET_PULSE_THRESHOLD)) mon (
	.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.syncResetN(syncResetN), .filterRestart(filterRestart), .internalOscOn(internalOscOn),
	.channelActive(channelActive), .powerLevel(powerLevel), .phaseCalEnable(phaseCalEnable),
	.resultReadyN(resultReadyN), .deviceResetActive(deviceResetActive));

// File: adms_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("[ERR] %s expected %h seen %h", nm, e, g); \
	end \
end
module tb;
	logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr, syncResetN = 1, modClockRun = 1, convDone, filterRestart;
	logic polarityInvert, modulatorRun, internalOscOn, phaseCalEnable, dcTestSelect;
	logic resultReadyN, deviceResetActive;
	logic [2:0] channelActive;
	logic [1:0] powerLevel;
	logic signed [23:0] amp = 24'sh001234;
	logic signed [23:0] convData [3];
	int bad_count = 0, cmp_count = 0, wn;
	adms_sequencer #(.RESET_PULSE_THRESHOLD(16), .MOD_DIV(32'd2),
		.SAMPLE_LUT('{12'd4, 12'd8, 12'd16, 12'd32, 12'd64, 12'd128, 12'd256, 12'd512})) uut (
		.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.syncResetN(syncResetN), .modClockRun(modClockRun), .convDone(convDone),
		.convData(convData), .filterRestart(filterRestart), .polarityInvert(polarityInvert),
		.modulatorRun(modulatorRun), .internalOscOn(internalOscOn),
		.channelActive(channelActive), .powerLevel(powerLevel), .phaseCalEnable(phaseCalEnable),
		.dcTestSelect(dcTestSelect), .resultReadyN(resultReadyN),
		.deviceResetActive(deviceResetActive));
	adms_filter_model filt (.core_clk(core_clk), .running(modulatorRun | internalOscOn),
		.filterRestart(filterRestart), .polarityInvert(polarityInvert), .amp(amp),
		.convDone(convDone), .convData(convData));
	always #10 core_clk = ~core_clk;
	// One APB transfer; it returns one edge after release so the next setup is clean.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	// Bounded wait on one pin; wn holds the cycle count, or -1 on a miss.
	task automatic waitsig(input int sel, input int lim);
		wn = -1;
		for (int i = 0; i < lim && wn < 0; i++) begin
			@(posedge core_clk);
			if ((sel == 0 && resultReadyN === 1'b0) || (sel == 1 && modulatorRun === 1'b1) ||
				(sel == 2 && internalOscOn === 1'b1) || (sel == 3 && filterRestart === 1'b1))
				wn = i;
		end
	endtask
	task automatic t_reset_vals();
		apb(1'b0, adms_pkg::OFS_CLOCK, 32'h0);
		`CHK("clock reset", adms_pkg::CLOCK_RST, rdat)
		apb(1'b0, adms_pkg::OFS_DETECT_CFG, 32'h0);
		`CHK("detect reset", adms_pkg::DETECT_CFG_RST, rdat)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped err", 1'b1, rerr)
		$display("reset values done");
	endtask
	task automatic t_power();
		for (int lv = 0; lv < 3; lv++) begin
			apb(1'b1, adms_pkg::OFS_CLOCK, 32'h0000_2007 | 32'(lv << 8));
			`CHK("powerLevel", 2'(lv), powerLevel)
		end
		apb(1'b1, adms_pkg::OFS_CLOCK, adms_pkg::CLOCK_RST);
		$display("power levels done");
	endtask
	task automatic t_chop();
		apb(1'b1, adms_pkg::OFS_CHOP_CFG, 32'h0000_0101);
		`CHK("phase cal off", 1'b0, phaseCalEnable)
		`CHK("dc test blocked", 1'b0, dcTestSelect)
		waitsig(0, 20000);
		`CHK("first result", 1'b1, wn >= 0)
		waitsig(0, 20000);
		`CHK("next result", 1'b1, wn >= 0)
		apb(1'b0, adms_pkg::OFS_RESULT, 32'h0);
		`CHK("chopped mean", 24'h001234, rdat[23:0])
		syncResetN <= 1'b0;
		waitsig(3, 12);
		`CHK("sync restart", 1'b1, wn >= 0)
		syncResetN <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK("no detect entry", 1'b0, internalOscOn)
		apb(1'b1, adms_pkg::OFS_CHOP_CFG, 32'h0);
		$display("chop done");
	endtask
	task automatic t_standby();
		amp <= 24'sh000100;
		apb(1'b1, adms_pkg::OFS_DETECT_LOWER, 32'h0000_0010);
		apb(1'b1, adms_pkg::OFS_DETECT_UPPER, 32'h0);
		apb(1'b1, adms_pkg::OFS_DETECT_CFG, 32'h0000_0001);
		apb(1'b1, adms_pkg::OFS_SERIAL_CMD, 32'(adms_pkg::CMD_STANDBY));
		modClockRun <= 1'b0;
		`CHK("channels off", 3'h0, channelActive)
		apb(1'b0, adms_pkg::OFS_DETECT_CFG, 32'h0);
		`CHK("config kept", 32'h0000_0001, rdat)
		syncResetN <= 1'b0;
		repeat (4) @(posedge core_clk);
		syncResetN <= 1'b1;
		waitsig(2, 20);
		`CHK("detect entered", 1'b1, wn >= 0)
		`CHK("modulator idle", 1'b0, modulatorRun)
		waitsig(0, 80000);
		`CHK("detect notify", 1'b1, wn >= 0)
		repeat (4) @(posedge core_clk);
		`CHK("back in standby", 1'b0, internalOscOn)
		apb(1'b1, adms_pkg::OFS_SERIAL_CMD, 32'(adms_pkg::CMD_WAKEUP));
		modClockRun <= 1'b1;
		waitsig(1, 200);
		`CHK("wake settle", 1'b1, wn >= adms_pkg::WAKE_SETTLE_MOD * 2)
		$display("standby and detect done");
	endtask
	task automatic t_pin_reset();
		apb(1'b1, adms_pkg::OFS_CLOCK, 32'h0000_2107);
		syncResetN <= 1'b0;
		repeat (30) @(posedge core_clk);
		`CHK("pin reset", 1'b1, deviceResetActive)
		syncResetN <= 1'b1;
		repeat (6) @(posedge core_clk);
		`CHK("pin released", 1'b0, deviceResetActive)
		apb(1'b0, adms_pkg::OFS_CLOCK, 32'h0);
		`CHK("defaults back", adms_pkg::CLOCK_RST, rdat)
		$display("pin reset done");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Watchdog sized above the 80000-cycle limit on the detect notify wait.
	initial begin
		repeat (90000) @(posedge core_clk);
		bad_count++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		t_reset_vals();
		t_power();
		t_chop();
		t_standby();
		t_pin_reset();
		final_report();
	end
endmodule // tb
